/* core/ucied_pkg.sv */
// Constants, layouts and carriers for the USB control and interrupt endpoint block
package ucied_pkg;
    // Interrupt status word layout
    localparam int          IRQ_W          = 32;
    localparam int          BIT_MAC_RTO    = 19;
    localparam int          BIT_RX_FRAME   = 18;
    localparam logic [31:0] IRQ_STICKY     = 32'h000b_ffff;
    localparam logic [11:0] IRQ_RSVD       = 12'h000;
    // Descriptor constants
    localparam logic [7:0]  DT_DEVICE      = 8'h01;
    localparam logic [7:0]  DT_CONFIG      = 8'h02;
    localparam logic [7:0]  DT_STRING      = 8'h03;
    localparam logic [7:0]  DEV_LEN        = 8'h12;
    localparam logic [7:0]  CFG_LEN        = 8'h09;
    localparam logic [15:0] CFG_TOTAL      = 16'h0027;
    localparam logic [15:0] USB_REL        = 16'h0200;
    localparam logic [7:0]  DEV_CLASS      = 8'hff;
    localparam logic [7:0]  DEV_SUBCLASS   = 8'h00;
    localparam logic [7:0]  DEV_PROTO      = 8'hff;
    localparam logic [7:0]  EP0_MAXPKT     = 8'h40;
    localparam logic [7:0]  NUM_CFG        = 8'h01;
    localparam logic [7:0]  NUM_IF         = 8'h01;
    localparam logic [7:0]  CFG_VALUE      = 8'h01;
    localparam logic [7:0]  CFG_ATTR       = 8'ha0;
    localparam logic [7:0]  MAXPOW_BUS     = 8'hfa;
    localparam logic [7:0]  MAXPOW_SELF    = 8'h01;
    localparam logic [7:0]  REL_LSB        = 8'h00;
    localparam logic [7:0]  STR_IDX_LAST   = 8'h05;
    localparam logic [15:0] VENDOR_LEN     = 16'h0004;
    localparam int          CFG_POW_LSB    = 64;
    // EEPROM image word map
    localparam logic [7:0]  EE_DEV_BASE    = 8'h80;
    localparam logic [7:0]  EE_CFG_BASE    = 8'h85;
    localparam logic [7:0]  EE_INTERVAL    = 8'h88;
    localparam logic [7:0]  POLL_DEFAULT   = 8'h04;
    // Register word addresses
    localparam logic [2:0]  REG_IRQ        = 3'h0;
    localparam logic [2:0]  REG_STATS      = 3'h1;
    localparam logic [2:0]  REG_STATUS     = 3'h2;
    localparam logic [2:0]  REG_CTRL       = 3'h3;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;

    typedef struct packed {
        logic        mac_reset_timeout_irq;
        logic        tx_halted_irq;
        logic        rx_halted_irq;
        logic        transceiver_irq;
        logic        tx_error_flag;
        logic        tx_fifo_underrun_flag;
        logic        tx_fifo_overrun_flag;
        logic        rx_drop_frame_irq;
        logic [10:0] gpio_irq;
    } ucied_irq_ev_s;

    typedef struct packed {
        logic        vendor;
        logic [7:0]  dtype;
        logic [7:0]  index;
        logic [15:0] length;
    } ucied_req_s;

    // First string-file word of each string index
    function automatic logic [6:0] str_base(input logic [2:0] idx);
        case (idx)
            3'd0:    str_base = 7'h00;
            3'd1:    str_base = 7'h04;
            3'd2:    str_base = 7'h1c;
            3'd3:    str_base = 7'h34;
            3'd4:    str_base = 7'h4c;
            default: str_base = 7'h64;
        endcase
    endfunction
endpackage

/* core/ucied_top.sv */
// Control endpoint unit, interrupt endpoint and descriptor store
`timescale 1ns/1ps
// Overview of operation
// [R1] Bit 18 shows a complete frame in receive FIFO; 19 timeout; 31:20 zero.
// [R2] Bits 17..11 carry the seven MAC flags, 10:0 the pin events.
// [R3] Each interrupt endpoint poll with a bit pending and ctrl bit 0 set returns the current status word.
// [R4] With nothing pending the poll is answered by NAK.
// [R5] Polling interval comes from EEPROM only; changes need EEPROM rewrite and reset.
// [R6] Status bits clear only by software write, never by endpoint reads.
// [R7] Endpoint zero handled here, with statistics and programmable descriptor parts.
// [R8] Protocol core hands over Get Descriptor and vendor requests for completion.
// [R9] Handed request pointer selects the descriptor and the returned data.
// [R10] Strings live in a 128 by 32 register file.
// [R11] String file reloads from EEPROM after every reset before serving.
// [R12] String index 0..5: language, maker, product, serial, configuration, interface.
// [R13] Device descriptor length 18 and its type always substituted.
// [R14] Device defaults: release 0200h, class FFh, sub 00h, protocol FFh, 40h.
// [R15] EEPROM must keep release, packet size, configuration count at defaults.
// [R16] Default device release: silicon release high byte, low byte 00h.
// [R17] Configuration defaults: length 09h, total 0027h, one interface.
// [R18] Attributes default A0h, replaced from EEPROM when present.
// [R19] Maximum power default advertises 500 mA, replaceable from EEPROM.
// [R20] Configuration type byte always substituted regardless of EEPROM.
// [R21] Default power byte: 01h self powered, FAh bus powered, by strap.
// [R22] String index beyond five is answered with STALL.
// [R23] Reply truncated to min of requested and actual length, in max packets.
module ucied_top #(
    parameter logic [15:0] VENDOR_ID   = 16'h1234, // Arbitrary value
    parameter logic [15:0] PRODUCT_ID  = 16'h5678, // Arbitrary value
    parameter logic [7:0]  SILICON_REL = 8'h07     // Arbitrary value
) (
    input  wire logic                    mclk,             // Clock, 25 MHz
    input  wire logic                    rst,              // Sync reset
    input  wire logic                    ce,               // Clock enable
    input  wire logic [2:0]              avs_address,      // Word address
    input  wire logic                    avs_read,         // Read request
    input  wire logic                    avs_write,        // Write request
    input  wire logic [31:0]             avs_writedata,    // Write data
    input  wire logic [3:0]              avs_byteenable,   // Byte lanes
    output logic [31:0]                  avs_readdata,     // Read data
    output logic                         avs_waitrequest,  // Stall master
    input  wire ucied_pkg::ucied_irq_ev_s irq_ev,          // Event pulses
    input  wire logic                    rx_fifo_has_frame,// Level
    input  wire logic                    ep3_token,        // Interrupt IN token
    output logic                         ep3_data_valid,   // Status word sent
    output logic [31:0]                  ep3_data,         // Status word
    output logic                         ep3_nak,          // NAK handshake
    output logic [7:0]                   poll_interval,    // Endpoint interval
    input  wire logic                    pwr_self_pin,     // Power strap pin
    input  wire logic                    ee_wr,            // EEPROM word valid
    input  wire logic [7:0]              ee_addr,          // EEPROM word index
    input  wire logic [31:0]             ee_data,          // EEPROM word
    input  wire logic                    ee_done,          // Image load end
    input  wire logic                    ee_present,       // EEPROM found
    input  wire logic                    req_valid,        // Request offered
    input  wire ucied_pkg::ucied_req_s   req,              // Request fields
    output logic                         req_ready,        // Request taken
    output logic                         tx_valid,         // Byte valid
    output logic [7:0]                   tx_data,          // Reply byte
    output logic                         tx_pkt_end,       // Last of packet
    input  wire logic                    tx_ready,         // Core takes byte
    output logic                         ep0_stall,        // STALL pulse
    output logic                         req_done          // Reply finished
);
    typedef enum logic [1:0] {ST_IDLE, ST_SEND} ucied_state_e;
    typedef enum logic [1:0] {K_DEV, K_CFG, K_STR, K_VND} ucied_kind_e;

    localparam logic [159:0] DEV_INIT = {16'h0000, ucied_pkg::NUM_CFG, 24'h000000,
        SILICON_REL, ucied_pkg::REL_LSB, PRODUCT_ID, VENDOR_ID, ucied_pkg::EP0_MAXPKT,
        ucied_pkg::DEV_PROTO, ucied_pkg::DEV_SUBCLASS, ucied_pkg::DEV_CLASS,
        ucied_pkg::USB_REL, ucied_pkg::DT_DEVICE, ucied_pkg::DEV_LEN}; // [R14] [R16]
    localparam logic [95:0] CFG_INIT = {24'h000000, ucied_pkg::MAXPOW_BUS,
        ucied_pkg::CFG_ATTR, 8'h00, ucied_pkg::CFG_VALUE, ucied_pkg::NUM_IF,
        ucied_pkg::CFG_TOTAL, ucied_pkg::DT_CONFIG, ucied_pkg::CFG_LEN}; // [R17] [R18] [R19]

    logic [31:0]  strf [0:127];
    logic [159:0] dev_v;
    logic [95:0]  cfg_v;
    logic         loaded;
    logic         pwr_meta;
    logic         pwr_self;
    logic [31:0]  irq_sticky;
    logic [31:0]  ctrl;
    logic [15:0]  desc_cnt;
    logic [15:0]  stall_cnt;
    logic         ack;
    ucied_state_e state;
    ucied_kind_e  kind;
    logic [6:0]   base;
    logic [15:0]  len;
    logic [15:0]  pos;
    logic [7:0]   pkt_cnt;

    // Avalon slave decode
    wire         bus_req   = avs_read | avs_write;
    wire         wr_fire   = avs_write & ack;
    wire  [31:0] be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire  [31:0] w1c       = (wr_fire && avs_address == ucied_pkg::REG_IRQ) ?
                             (avs_writedata & be_mask) : 32'h0000_0000;
    assign avs_waitrequest = bus_req & ~ack;

    // Interrupt status word
    wire  [31:0] ev_set    = {ucied_pkg::IRQ_RSVD, irq_ev.mac_reset_timeout_irq, 1'b0,
                              irq_ev.tx_halted_irq, irq_ev.rx_halted_irq, irq_ev.transceiver_irq,
                              irq_ev.tx_error_flag, irq_ev.tx_fifo_underrun_flag,
                              irq_ev.tx_fifo_overrun_flag, irq_ev.rx_drop_frame_irq,
                              irq_ev.gpio_irq}; // [R2]
    wire  [31:0] irq_word  = (irq_sticky & ucied_pkg::IRQ_STICKY)
                             | ({31'h0, rx_fifo_has_frame} << ucied_pkg::BIT_RX_FRAME); // [R1]
    wire         pending   = |irq_word;

    wire  [31:0] rd_mux    = (avs_address == ucied_pkg::REG_IRQ)    ? irq_word :
                             (avs_address == ucied_pkg::REG_STATS)  ? {stall_cnt, desc_cnt} :
                             (avs_address == ucied_pkg::REG_STATUS) ?
                                 {22'h0, poll_interval, pwr_self, loaded} :
                             (avs_address == ucied_pkg::REG_CTRL)   ? ctrl : 32'h0000_0000;

    // Request classification
    wire         is_dev    = req.dtype == ucied_pkg::DT_DEVICE;
    wire         is_cfg    = req.dtype == ucied_pkg::DT_CONFIG;
    wire         is_str    = req.dtype == ucied_pkg::DT_STRING;
    wire         str_ok    = req.index <= ucied_pkg::STR_IDX_LAST; // [R12]
    wire         bad_req   = !req.vendor && !(is_dev || (is_cfg) || (is_str && str_ok)); // [R22]
    wire  [6:0]  req_base  = req.vendor ? req.index[6:0] : ucied_pkg::str_base(req.index[2:0]);
    wire  [15:0] str_len   = {8'h00, strf[req_base][7:0]};
    wire  [15:0] act_len   = req.vendor ? ucied_pkg::VENDOR_LEN :
                             is_dev     ? {8'h00, ucied_pkg::DEV_LEN} :
                             is_cfg     ? {8'h00, ucied_pkg::CFG_LEN} : str_len;
    wire  [15:0] cut_len   = (req.length < act_len) ? req.length : act_len; // [R23]
    wire         take      = req_valid & req_ready;
    assign req_ready       = loaded && state == ST_IDLE; // [R11]

    // Byte source for the reply stream
    wire  [6:0]  str_word  = base + pos[8:2];
    wire  [31:0] sword     = strf[str_word];
    wire  [7:0]  str_byte  = sword[{pos[1:0], 3'b000} +: 8];
    wire  [7:0]  dev_byte  = (pos == 16'h0000) ? ucied_pkg::DEV_LEN :
                             (pos == 16'h0001) ? ucied_pkg::DT_DEVICE :
                             dev_v[{pos[4:0], 3'b000} +: 8]; // [R13]
    wire  [7:0]  cfg_byte  = (pos == 16'h0000) ? ucied_pkg::CFG_LEN :
                             (pos == 16'h0001) ? ucied_pkg::DT_CONFIG :
                             cfg_v[{pos[3:0], 3'b000} +: 8]; // [R20]
    wire  [7:0]  src_byte  = (kind == K_DEV) ? dev_byte :
                             (kind == K_CFG) ? cfg_byte : str_byte; // [R9]
    wire         can_load  = !tx_valid || tx_ready;
    wire         more      = pos != len;
    wire  [15:0] pos_nxt   = pos + 16'h0001;
    wire  [7:0]  pkt_nxt   = pkt_cnt + 8'h01;
    wire  [7:0]  maxpkt    = dev_v[63:56];
    wire         pkt_last  = (pkt_nxt == maxpkt) || (pos_nxt == len);

    // Strap catch after reset release
    always_ff @(posedge mclk) begin
        if (rst) begin
            pwr_meta <= 1'b0;
            pwr_self <= 1'b0;
        end else if (ce) begin
            pwr_meta <= pwr_self_pin;
            pwr_self <= pwr_meta;
        end
    end

    // String file load
    always_ff @(posedge mclk) begin
        if (ce && ee_wr && !ee_addr[7]) begin
            strf[ee_addr[6:0]] <= ee_data; // [R10] [R11]
        end
    end

    // Descriptor store and interval
    always_ff @(posedge mclk) begin
        if (rst) begin
            dev_v         <= DEV_INIT;
            cfg_v         <= CFG_INIT;
            poll_interval <= ucied_pkg::POLL_DEFAULT;
            loaded        <= 1'b0;
        end else if (ce) begin
            if (ee_wr && ee_addr >= ucied_pkg::EE_DEV_BASE && ee_addr < ucied_pkg::EE_CFG_BASE) begin
                dev_v[{ee_addr[2:0], 5'b00000} +: 32] <= ee_data; // [R7]
            end
            if (ee_wr && ee_addr >= ucied_pkg::EE_CFG_BASE && ee_addr < ucied_pkg::EE_INTERVAL) begin
                cfg_v[{ee_addr[1:0] - 2'd1, 5'b00000} +: 32] <= ee_data; // [R18] [R19]
            end
            if (ee_wr && ee_addr == ucied_pkg::EE_INTERVAL) begin
                poll_interval <= ee_data[7:0]; // [R5]
            end
            if (ee_done) begin
                loaded <= 1'b1;
            end
            if (ee_done && !ee_present) begin
                cfg_v[ucied_pkg::CFG_POW_LSB +: 8] <= pwr_self ? ucied_pkg::MAXPOW_SELF
                                                               : ucied_pkg::MAXPOW_BUS; // [R21]
            end
        end
    end

    // Register bus and status flags
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            irq_sticky   <= 32'h0000_0000;
            ctrl         <= ucied_pkg::CTRL_RESET;
        end else if (ce) begin
            ack <= bus_req & ~ack;
            if (avs_read && !ack) begin
                avs_readdata <= rd_mux;
            end
            irq_sticky <= (irq_sticky & ~w1c) | ev_set; // [R6]
            if (wr_fire && avs_address == ucied_pkg::REG_CTRL) begin
                ctrl <= (ctrl & ~be_mask) | (avs_writedata & be_mask);
            end
        end
    end

    // Interrupt endpoint answer
    always_ff @(posedge mclk) begin
        if (rst) begin
            ep3_data_valid <= 1'b0;
            ep3_nak        <= 1'b0;
            ep3_data       <= 32'h0000_0000;
        end else if (ce) begin
            ep3_data_valid <= ep3_token & pending & ctrl[0]; // [R3]
            ep3_nak        <= ep3_token & ~(pending & ctrl[0]); // [R4]
            if (ep3_token) begin
                ep3_data <= irq_word; // [R3] [R6]
            end
        end
    end

    // Control endpoint reply engine
    always_ff @(posedge mclk) begin
        if (rst) begin
            state      <= ST_IDLE;
            kind       <= K_DEV;
            base       <= 7'h00;
            len        <= 16'h0000;
            pos        <= 16'h0000;
            pkt_cnt    <= 8'h00;
            tx_valid   <= 1'b0;
            tx_data    <= 8'h00;
            tx_pkt_end <= 1'b0;
            ep0_stall  <= 1'b0;
            req_done   <= 1'b0;
            desc_cnt   <= 16'h0000;
            stall_cnt  <= 16'h0000;
        end else if (ce) begin
            ep0_stall <= 1'b0;
            req_done  <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (take && bad_req) begin
                        ep0_stall <= 1'b1; // [R22]
                        stall_cnt <= stall_cnt + 16'h0001;
                    end else if (take) begin
                        state    <= ST_SEND; // [R8]
                        kind     <= req.vendor ? K_VND : is_dev ? K_DEV : is_cfg ? K_CFG : K_STR;
                        base     <= req_base;
                        len      <= cut_len; // [R23]
                        pos      <= 16'h0000;
                        pkt_cnt  <= 8'h00;
                        desc_cnt <= desc_cnt + 16'h0001; // [R7]
                    end
                end
                ST_SEND: begin
                    if (can_load && more) begin
                        tx_data    <= src_byte;
                        tx_valid   <= 1'b1;
                        tx_pkt_end <= pkt_last; // [R23]
                        pos        <= pos_nxt;
                        pkt_cnt    <= pkt_last ? 8'h00 : pkt_nxt;
                    end else if (can_load) begin
                        tx_valid   <= 1'b0;
                        tx_pkt_end <= 1'b0;
                        req_done   <= 1'b1;
                        state      <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // ucied_top

/* test/ucied_top_asserts.sv */
// Checker for interrupt endpoint and control reply timing at the block ports
`timescale 1ns/1ps
module ucied_top_asserts (
    input wire logic                     mclk,              // Clock
    input wire logic                     rst,               // Sync reset
    input wire logic                     ce,                // Clock enable
    input wire ucied_pkg::ucied_irq_ev_s irq_ev,            // Event pulses
    input wire logic                     rx_fifo_has_frame, // Frame level
    input wire logic                     ep3_token,         // IN token
    input wire logic                     ep3_data_valid,    // Word sent
    input wire logic [31:0]              ep3_data,          // Status word
    input wire logic                     ep3_nak,           // NAK
    input wire logic [7:0]               poll_interval,     // Interval
    input wire logic                     req_valid,         // Request offered
    input wire ucied_pkg::ucied_req_s    req,               // Request fields
    input wire logic                     req_ready,         // Request taken
    input wire logic                     tx_valid,          // Byte valid
    input wire logic [7:0]               tx_data,           // Reply byte
    input wire logic                     tx_ready,          // Byte taken
    input wire logic                     ep0_stall          // STALL
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_tok; ep3_token && ce |=> ep3_data_valid != ep3_nak; endproperty
    a_tok: assert property (p_tok) else $error("token answered by neither or both");
    property p_rsvd; ep3_data_valid |-> ep3_data[31:20] == 12'h000; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
    property p_frame; ep3_data_valid |-> ep3_data[18] == $past(rx_fifo_has_frame); endproperty
    a_frame: assert property (p_frame) else $error("frame bit not live");
    property p_pend; ep3_data_valid |-> ep3_data != 32'h0; endproperty
    a_pend: assert property (p_pend) else $error("empty word sent instead of nak");
    property p_sticky; irq_ev.tx_halted_irq && ce ##1 ep3_token && ce |=> ep3_data_valid && ep3_data[17]; endproperty
    a_sticky: assert property (p_sticky) else $error("tx halted event not reported");
    property p_hold; tx_valid && !tx_ready && ce |=> tx_valid && $stable(tx_data); endproperty
    a_hold: assert property (p_hold) else $error("reply byte dropped while stalled");
    property p_poll; $fell(rst) |-> poll_interval == ucied_pkg::POLL_DEFAULT; endproperty
    a_poll: assert property (p_poll) else $error("interval not default after reset");
    property p_dev; req_valid && req_ready && ce && !req.vendor && req.dtype == ucied_pkg::DT_DEVICE
        && req.length != 16'h0 |-> ##2 tx_valid && tx_data == ucied_pkg::DEV_LEN; endproperty
    a_dev: assert property (p_dev) else $error("device reply does not open with length");
    property p_str; req_valid && req_ready && !req.vendor && req.dtype == ucied_pkg::DT_STRING
        && req.index > ucied_pkg::STR_IDX_LAST |=> ep0_stall; endproperty
    a_str: assert property (p_str) else $error("bad string index not stalled");
endmodule // ucied_top_asserts
bind ucied_top ucied_top_asserts chk_u (.*);

/* test/ucied_host_model.sv */
// Host controller model: polls the interrupt endpoint and runs control transfers
`timescale 1ns/1ps
module ucied_host_model (
    input  wire logic             mclk,           // Clock
    output logic                  ep3_token,      // IN token
    input  wire logic             ep3_data_valid, // Word sent
    input  wire logic [31:0]      ep3_data,       // Status word
    input  wire logic             ep3_nak,        // NAK
    output logic                  req_valid,      // Request offered
    output ucied_pkg::ucied_req_s req,            // Request fields
    input  wire logic             req_ready,      // Request taken
    input  wire logic             tx_valid,       // Byte valid
    input  wire logic [7:0]       tx_data,        // Reply byte
    input  wire logic             tx_pkt_end,     // Packet end
    output logic                  tx_ready,       // Byte taken
    input  wire logic             ep0_stall,      // STALL
    input  wire logic             req_done        // Reply finished
);
    logic [8:0]  rx_q [$];
    logic        got_stall;
    logic        p_nak;
    logic [31:0] p_word;
    initial begin
        ep3_token = 1'b0;
        req_valid = 1'b0;
        req       = '0;
        tx_ready  = 1'b0;
    end
    task automatic poll();
        ep3_token <= 1'b1;
        @(posedge mclk);
        ep3_token <= 1'b0;
        @(posedge mclk);
        p_nak  = ep3_nak;
        p_word = ep3_data;
    endtask
    // Slow mode takes a byte only every other cycle
    task automatic fetch(input ucied_pkg::ucied_req_s r, input logic slow);
        rx_q.delete();
        got_stall = 1'b0;
        req       <= r;
        req_valid <= 1'b1;
        do begin
            @(posedge mclk);
        end while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        req       <= ~r;
        forever begin
            @(posedge mclk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) rx_q.push_back({tx_pkt_end, tx_data});
            if (ep0_stall === 1'b1) got_stall = 1'b1;
            if (ep0_stall === 1'b1 || req_done === 1'b1) break;
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
        tx_ready <= 1'b0;
    endtask
endmodule // ucied_host_model

/* test/tb_top.sv */
// Testbench: EEPROM load, interrupt endpoint, register bus and descriptor replies
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, rx_fifo_has_frame = 1'b0;
    logic pwr_self_pin = 1'b0, ee_wr = 1'b0, ee_done = 1'b0, ee_present = 1'b0;
    logic [2:0]  avs_address = 3'h0;
    logic [7:0]  ee_addr = 8'h0, poll_interval, tx_data;
    logic [31:0] avs_writedata = 32'h0, ee_data = 32'h0, avs_readdata, ep3_data;
    logic ep3_token, ep3_data_valid, ep3_nak, req_valid, req_ready, tx_valid, tx_pkt_end, tx_ready;
    logic ep0_stall, req_done, avs_waitrequest;
    ucied_pkg::ucied_irq_ev_s irq_ev = '0;
    ucied_pkg::ucied_req_s    req;
    int errors = 0;
    int compares = 0;
    logic [39:0] img [7] = '{{8'h80, 32'h0200_5555}, {8'h81, 32'h40ff_00ff}, {8'h85, 32'h0027_3333},
        {8'h86, 32'ha000_0101}, {8'h87, 32'h0000_0032}, {8'h88, 32'h0000_000a}, {8'h04, 32'h0041_0304}};
    ucied_top dut_u (.ce(1'b1), .avs_byteenable(4'hf), .*);
    ucied_host_model host_u (.*);
    initial forever #20 mclk = ~mclk;
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_bytes(input string nm, input logic [71:0] exp, input int cnt);
        chk(nm, cnt, host_u.rx_q.size());
        for (int i = 0; i < cnt && i < 9; i++) chk(nm, exp[8*i+:8], host_u.rx_q[i][7:0]);
    endtask
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= ~wr;
        avs_write     <= wr;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    // Reset, then hand over the EEPROM image when present
    task automatic reset_load(input logic pres);
        rst <= 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        // Strap must clear its synchroniser before ee_done
        repeat (2) @(posedge mclk);
        chk("ready before load", 32'h0, req_ready);
        chk("interval at reset", 32'h04, poll_interval);
        for (int i = 0; i < 7 && pres; i++) begin
            ee_wr <= 1'b1;
            {ee_addr, ee_data} <= img[i];
            @(posedge mclk);
        end
        ee_wr      <= 1'b0;
        ee_done    <= 1'b1;
        ee_present <= pres;
        @(posedge mclk);
        ee_done <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic desc(input logic v, input logic [7:0] t, input logic [7:0] i, input logic [15:0] l);
        host_u.fetch({v, t, i, l}, 1'b1);
    endtask
    task automatic t_irq();
        logic [31:0] q;
        host_u.poll();
        chk("nak when idle", 32'h1, host_u.p_nak);
        irq_ev <= 19'h60001;
        @(posedge mclk);
        irq_ev <= '0;
        host_u.poll();
        chk("status word", 32'h000a_0001, host_u.p_word);
        rx_fifo_has_frame <= 1'b1;
        host_u.poll();
        chk("word after poll", 32'h000e_0001, host_u.p_word);
        rx_fifo_has_frame <= 1'b0;
        bus(1'b1, ucied_pkg::REG_IRQ, 32'h000a_0001, q);
        host_u.poll();
        chk("nak after clear", 32'h1, host_u.p_nak);
        rx_fifo_has_frame <= 1'b1;
        bus(1'b1, ucied_pkg::REG_CTRL, 32'h0, q);
        host_u.poll();
        chk("nak when disabled", 32'h1, host_u.p_nak);
        rx_fifo_has_frame <= 1'b0;
        bus(1'b1, ucied_pkg::REG_CTRL, 32'h1, q);
        bus(1'b0, 3'h5, 32'h0, q);
        chk("unmapped read", 32'h0, q);
        bus(1'b0, ucied_pkg::REG_STATUS, 32'h0, q);
        chk("status interval", 32'h0a, q[9:2]);
        chk("poll interval", 32'h0a, poll_interval);
    endtask
    task automatic t_desc();
        desc(1'b0, ucied_pkg::DT_DEVICE, 8'h00, 16'h00ff);
        chk_bytes("device", {8'h34, 8'h40, 8'hff, 8'h00, 8'hff, 8'h02, 8'h00, 8'h01, 8'h12}, 18);
        chk("device end", 32'h1, host_u.rx_q[17][8]);
        chk("device mid", 32'h0, host_u.rx_q[16][8]);
        desc(1'b0, ucied_pkg::DT_CONFIG, 8'h00, 16'h00ff);
        chk_bytes("config", 72'h32_a000_0101_0027_0209, 9);
        desc(1'b0, ucied_pkg::DT_STRING, 8'h01, 16'h00ff);
        chk_bytes("string", 72'h0041_0304, 4);
        desc(1'b0, ucied_pkg::DT_STRING, 8'h01, 16'h0002);
        chk_bytes("string short", 72'h0304, 2);
        desc(1'b0, ucied_pkg::DT_STRING, 8'h06, 16'h00ff);
        chk("stall", 32'h1, host_u.got_stall);
        desc(1'b1, 8'h00, 8'h04, 16'h0004);
        chk_bytes("vendor", 72'h0041_0304, 4);
    endtask
    task automatic t_self_power();
        logic [31:0] q;
        pwr_self_pin <= 1'b1;
        reset_load(1'b0);
        host_u.fetch({1'b0, ucied_pkg::DT_CONFIG, 8'h00, 16'h00ff}, 1'b0);
        chk("self power", ucied_pkg::MAXPOW_SELF, host_u.rx_q[8][7:0]);
        bus(1'b0, ucied_pkg::REG_STATS, 32'h0, q);
        chk("stats", 32'h0000_0001, q);
    endtask
    task automatic end_of_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        reset_load(1'b1);
        t_irq();
        t_desc();
        t_self_power();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        end_of_test();
    end
endmodule // tb_top
